//--- bench/gated_timer_counter_16bit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gated_timer_counter_16bit_tb;
   import gtc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic overflowIrq;
   logic instClkTick = 1'b0;
   logic oscClkTick = 1'b0;
   logic specialEventTrigger = 1'b0;
   wire logic extClockPin, secondaryOscillator, lowPowerRcOsc;
   wire logic gateInputPin, comparatorOne, comparatorTwo;
   int failures = 0;
   int checksDone = 0;
   int irqSeen = 0;
   int modelCount = 0;
   int seed = 38919;
   int n;
   logic [31:0] rd;
   logic errSeen;

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (overflowIrq === 1'b1) irqSeen++;
   end

   gtc_timer i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instClkTick(instClkTick), .oscClkTick(oscClkTick),
      .lowPowerRcOsc(lowPowerRcOsc), .secondaryOscillator(secondaryOscillator),
      .extClockPin(extClockPin), .gateInputPin(gateInputPin),
      .comparatorOne(comparatorOne), .comparatorTwo(comparatorTwo),
      .specialEventTrigger(specialEventTrigger), .overflowIrq(overflowIrq));
   gtc_ext_source i_src (.clk_sys(clk_sys), .extClockPin(extClockPin),
      .secondaryOscillator(secondaryOscillator),
      .lowPowerRcOsc(lowPowerRcOsc), .gateInputPin(gateInputPin),
      .comparatorOne(comparatorOne), .comparatorTwo(comparatorTwo));

   task automatic summarize();
      $display("checks %0d mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one APB transfer; waits on pready since the slave sets the pace
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (!(pready === 1'b1) && k < 50);
      if (k >= 50) failures++;
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic checkVal(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdChk(input string what, input logic [11:0] a,
                        input logic [31:0] mask, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      checkVal(what, exp, rd & mask);
      checkVal("pslverr", 32'h0, {31'h0, errSeen});
   endtask

   // src 0 instruction tick, 1 oscillator tick, 2.. partner clock lines
   task automatic run(input logic [31:0] ctl, input int src, input int cnt,
                      input int adds);
      apb(ADDR_CONTROL, 1'b1, ctl);
      if (src >= 2) begin
         i_src.edges(src - 2, cnt);
      end else begin
         repeat (cnt) begin
            @(posedge clk_sys);
            if (src == 1) oscClkTick <= 1'b1;
            else instClkTick <= 1'b1;
            @(posedge clk_sys);
            oscClkTick <= 1'b0;
            instClkTick <= 1'b0;
         end
         repeat (4) @(posedge clk_sys);
      end
      apb(ADDR_CONTROL, 1'b1, 32'h0);
      modelCount = (modelCount + adds) & 32'hffff;
      rdChk("count", ADDR_COUNT_VALUE, 32'hffff, modelCount);
   endtask

   initial begin
      #500000;
      failures++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rdChk("control", ADDR_CONTROL, 32'hff, {24'h0, CONTROL_RESET});
      rdChk("gate ctl", ADDR_GATE_CONTROL, 32'hfb,
            {24'h0, GATE_CONTROL_RESET});
      rdChk("count", ADDR_COUNT_VALUE, 32'hffff, 32'h0);
      rdChk("period", ADDR_PERIOD_VALUE, 32'hff, {24'h0, PERIOD_RESET});
      rdChk("unmapped", 12'h0f0, 32'hffffffff, 32'h0);
      $display("test reset values done");
      modelCount = $random(seed) & 32'hffff;
      apb(ADDR_COUNT_VALUE, 1'b1, modelCount);
      run(32'h0, 0, 5, 0);
      for (int ps = 0; ps < 4; ps++) begin
         run((ps << CTL_PRESCALE_LO) | 1, 0, 16, 16 >> ps);
      end
      n = 3 + ($unsigned($random(seed)) % 6);
      run(32'h1, 0, n, n);
      run(32'h41, 1, n, n);
      $display("test internal clocks done");
      modelCount = 32'hfffe;
      apb(ADDR_COUNT_VALUE, 1'b1, modelCount);
      irqSeen = 0;
      run(32'h1, 0, 3, 3);
      checkVal("irq pulses", 32'h1, irqSeen);
      apb(ADDR_CONTROL, 1'b1, 32'h1);
      @(posedge clk_sys);
      specialEventTrigger <= 1'b1;
      @(posedge clk_sys);
      specialEventTrigger <= 1'b0;
      apb(ADDR_CONTROL, 1'b1, 32'h0);
      modelCount = 0;
      rdChk("count", ADDR_COUNT_VALUE, 32'hffff, 32'h0);
      $display("test overflow and trigger done");
      run(32'h81, 2, n, n);
      run(32'h85, 2, n, n);
      run(32'h89, 3, n, n);
      run(32'hc1, 4, n, n);
      $display("test external clocks done");
      for (int s = 0; s < 4; s++) begin
         if (s == 1) continue;
         apb(ADDR_GATE_CONTROL, 1'b1, 32'hc0 | s);
         run(32'h1, 0, 4, 0);
         i_src.setGate(s == 0 ? 0 : s - 1, 1'b1);
         run(32'h1, 0, 4, 4);
         rdChk("gate value", ADDR_GATE_CONTROL, 32'h4, 32'h4);
         i_src.setGate(s == 0 ? 0 : s - 1, 1'b0);
      end
      // period zero keeps the match pulse high every cycle
      apb(ADDR_PERIOD_VALUE, 1'b1, 32'h0);
      apb(ADDR_PERIOD_COUNT, 1'b1, 32'h0);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'hc1);
      run(32'h1, 0, 4, 4);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'h81);
      run(32'h1, 0, 4, 0);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'h80);
      run(32'h1, 0, 4, 4);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'h40);
      run(32'h1, 0, 4, 4);
      rdChk("gate value", ADDR_GATE_CONTROL, 32'h4, 32'h0);
      $display("test gate sources done");
      apb(ADDR_GATE_CONTROL, 1'b1, 32'he0);
      i_src.setGate(0, 1'b1);
      i_src.setGate(0, 1'b0);
      rdChk("gate value", ADDR_GATE_CONTROL, 32'h4, 32'h4);
      run(32'h1, 0, 3, 3);
      i_src.setGate(0, 1'b1);
      i_src.setGate(0, 1'b0);
      run(32'h1, 0, 3, 0);
      $display("test toggle done");
      apb(ADDR_GATE_CONTROL, 1'b1, 32'hd8);
      rdChk("arm", ADDR_GATE_CONTROL, 32'h8, 32'h8);
      run(32'h1, 0, 3, 0);
      i_src.setGate(0, 1'b1);
      run(32'h1, 0, 3, 3);
      i_src.setGate(0, 1'b0);
      rdChk("arm", ADDR_GATE_CONTROL, 32'h8, 32'h0);
      i_src.setGate(0, 1'b1);
      run(32'h1, 0, 3, 0);
      i_src.setGate(0, 1'b0);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'hd8);
      apb(ADDR_GATE_CONTROL, 1'b1, 32'hc8);
      rdChk("arm", ADDR_GATE_CONTROL, 32'h8, 32'h0);
      $display("test single pulse done");
      summarize();
   end
endmodule
`default_nettype wire

//--- bench/gtc_ext_source.sv
`timescale 1ns/10ps
`default_nettype none
// far side: external clock lines and gate sources, all driven after edges
module gtc_ext_source (
   input wire logic clk_sys,
   output logic extClockPin,
   output logic secondaryOscillator,
   output logic lowPowerRcOsc,
   output logic gateInputPin,
   output logic comparatorOne,
   output logic comparatorTwo
);
   logic [2:0] clkLine = 3'h0;
   logic [2:0] gateLine = 3'h0;
   assign extClockPin = clkLine[0];
   assign secondaryOscillator = clkLine[1];
   assign lowPowerRcOsc = clkLine[2];
   assign gateInputPin = gateLine[0];
   assign comparatorOne = gateLine[1];
   assign comparatorTwo = gateLine[2];
   // slow edges, idle low between bursts: never the undivided clock
   // two cycles high and low so the synchronizer sees every edge
   task automatic edges(input int which, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         clkLine[which] <= 1'b1;
         repeat (2) @(posedge clk_sys);
         clkLine[which] <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask
   // gate levels are held five cycles so the gate registers settle before anyone looks
   task automatic setGate(input int which, input logic lvl);
      @(posedge clk_sys);
      gateLine[which] <= lvl;
      repeat (5) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

//--- hw/gtc_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
// brings a source level into clk_sys and gives its rising edge
module gtc_edge_sync
   import gtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic srcLevel,
   input wire logic bypassSync,
   output logic syncLevel,
   output logic riseEdge
);
   logic meta_reg;
   logic stage_reg;
   logic last_reg;
   logic pick;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b0;
         stage_reg <= 1'b0;
      end else begin
         meta_reg <= srcLevel;
         stage_reg <= meta_reg;
      end
   end
   // bypass saves two cycles of latency but trusts the source timing
   assign pick = bypassSync ? srcLevel : stage_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= pick;
      end
   end
   assign syncLevel = pick;
   assign riseEdge = pick & ~last_reg;
endmodule
`default_nettype wire

//--- hw/gtc_period_timer.sv
`timescale 1ns/10ps
`default_nettype none
// 8-bit period timer, source of the period-match gate
module gtc_period_timer
   import gtc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic countWrite,
   input wire logic periodWrite,
   input wire logic [WIDTH-1:0] writeData,
   output logic [WIDTH-1:0] periodCount,
   output logic [WIDTH-1:0] periodValue,
   output logic matchPulse
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] period_reg;
   logic match_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         period_reg <= WIDTH'(PERIOD_RESET);
      end else if (periodWrite) begin
         period_reg <= writeData;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
         match_reg <= 1'b0;
      end else if (countWrite) begin
         count_reg <= writeData;
         match_reg <= 1'b0;
      end else if (count_reg == period_reg) begin
         count_reg <= '0;
         match_reg <= 1'b1;
      end else begin
         count_reg <= count_reg + WIDTH'(1);
         match_reg <= 1'b0;
      end
   end
   assign periodCount = count_reg;
   assign periodValue = period_reg;
   assign matchPulse = match_reg;
endmodule
`default_nettype wire

//--- hw/gtc_pkg.sv
package gtc_pkg;
   // register byte addresses on the APB slave
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_GATE_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_COUNT_VALUE = 12'h008;
   localparam logic [11:0] ADDR_PERIOD_COUNT = 12'h00c;
   localparam logic [11:0] ADDR_PERIOD_VALUE = 12'h010;
   // control register fields
   localparam int CTL_TIMER_ON = 0;
   localparam int CTL_SYNC_BYPASS = 2;
   localparam int CTL_SECONDARY_OSCILLATOR_EN = 3;
   localparam int CTL_PRESCALE_LO = 4;
   localparam int CTL_CLKSRC_LO = 6;
   // gate control register fields
   localparam int GCT_SRC_LO = 0;
   localparam int GCT_VALUE = 2;
   localparam int GCT_ARM = 3;
   localparam int GCT_SPM = 4;
   localparam int GCT_TOGGLE = 5;
   localparam int GCT_POL = 6;
   localparam int GCT_ENABLE = 7;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [2:0] PRESCALE_CNT_RESET = 3'h0;
   typedef enum logic [1:0] {
      GTC_CLK_INST = 2'b00,
      GTC_CLK_OSC = 2'b01,
      GTC_CLK_EXT = 2'b10,
      GTC_CLK_LOW_POWER_RC_OSC = 2'b11
   } gtc_clksrc_t;
   typedef enum logic [1:0] {
      GTC_GATE_PIN = 2'b00,
      GTC_GATE_PERIOD = 2'b01,
      GTC_GATE_CMP1 = 2'b10,
      GTC_GATE_CMP2 = 2'b11
   } gtc_gatesrc_t;
   typedef enum logic [1:0] {
      GTC_SP_IDLE = 2'b00,
      GTC_SP_WAIT = 2'b01,
      GTC_SP_PULSE = 2'b10
   } gtc_spstate_t;
endpackage

//--- hw/gtc_timer.sv
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - software picks timer on an internal clock or counter of external edges
// - one 16-bit count register, readable and writable at any time
// - clock source: instruction clock, oscillator, external or low-power RC
// - interrupt request pulses when the count rolls from ffff to zero
// - special event trigger from the capture unit clears the count
// - sync bypass bit 1 skips external synchronization, 0 synchronizes
// - gate enable only matters while the timer is on
// - gate polarity 1 counts on high gate, 0 on low gate
// - toggle mode: flip-flop toggles on each rising gate edge and becomes the gate
// - single pulse mode: one armed pulse opens one counting window
// - software arms, device waits for the gate to open, then clears the arm bit when it closes
// - clearing single pulse mode clears the arm bit
// - gate value status shows the effective gate regardless of enable
// - gate source: 00 pin, 01 period match, 10 comparator 1, 11 comparator 2
// - period timer emits a match pulse usable as a gate
module gtc_timer
   import gtc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instClkTick,
   input wire logic oscClkTick,
   input wire logic lowPowerRcOsc,
   input wire logic secondaryOscillator,
   input wire logic extClockPin,
   input wire logic gateInputPin,
   input wire logic comparatorOne,
   input wire logic comparatorTwo,
   input wire logic specialEventTrigger,
   output logic overflowIrq
);
   logic [7:0] control_reg;
   logic [1:0] gateCfgSrc_reg;
   logic [GCT_POL:GCT_SPM] gateCfg_reg;
   logic gateCfgEnable_reg;
   logic arm_reg;
   logic [15:0] count_reg;
   logic [2:0] prescale_reg;
   logic toggle_reg;
   logic gateLast_reg;
   logic irq_reg;
   gtc_spstate_t spState_reg;
   logic [31:0] rdata_next;
   logic wrEn;
   logic extRise;
   logic lprcRise;
   logic extSel;
   logic tick;
   logic prescaleHit;
   logic rawGate;
   logic polGate;
   logic effGate;
   logic gateOpen;
   logic countStep;
   logic [7:0] ptCount;
   logic [7:0] ptPeriod;
   logic ptMatch;
   logic [2:0] divMask;
   gtc_clksrc_t clkSrc;
   assign clkSrc = gtc_clksrc_t'(control_reg[CTL_CLKSRC_LO +: 2]);
   assign wrEn = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // external edge source, synchronised unless bypass is set
   assign extSel = control_reg[CTL_SECONDARY_OSCILLATOR_EN] ? secondaryOscillator
                                            : extClockPin;
   gtc_edge_sync extSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .srcLevel(extSel),
      .bypassSync(control_reg[CTL_SYNC_BYPASS]),
      .syncLevel(),
      .riseEdge(extRise)
   );
   gtc_edge_sync lprcSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .srcLevel(lowPowerRcOsc),
      .bypassSync(1'b0),
      .syncLevel(),
      .riseEdge(lprcRise)
   );
   gtc_period_timer periodTimer (
      .clk_sys(clk_sys),
      .rst(rst),
      .countWrite(wrEn && paddr == ADDR_PERIOD_COUNT),
      .periodWrite(wrEn && paddr == ADDR_PERIOD_VALUE),
      .writeData(pwdata[7:0]),
      .periodCount(ptCount),
      .periodValue(ptPeriod),
      .matchPulse(ptMatch)
   );
   always_comb begin
      case (clkSrc)
         GTC_CLK_INST: tick = instClkTick;
         GTC_CLK_OSC: tick = oscClkTick;
         GTC_CLK_EXT: tick = extRise;
         default: tick = lprcRise;
      endcase
   end
   // prescaler: 1, 2, 4 or 8 source ticks per count
   always_comb begin
      case (control_reg[CTL_PRESCALE_LO +: 2])
         2'b00: divMask = 3'h0;
         2'b01: divMask = 3'h1;
         2'b10: divMask = 3'h3;
         default: divMask = 3'h7;
      endcase
   end
   assign prescaleHit = tick && ((prescale_reg & divMask) == divMask);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prescale_reg <= PRESCALE_CNT_RESET;
      end else if (wrEn && paddr == ADDR_CONTROL) begin
         prescale_reg <= PRESCALE_CNT_RESET;
      end else if (tick && control_reg[CTL_TIMER_ON]) begin
         prescale_reg <= prescaleHit ? PRESCALE_CNT_RESET
                                     : prescale_reg + 3'h1;
      end
   end
   // gate path
   always_comb begin
      case (gtc_gatesrc_t'(gateCfgSrc_reg))
         GTC_GATE_PIN: rawGate = gateInputPin;
         GTC_GATE_PERIOD: rawGate = ptMatch;
         GTC_GATE_CMP1: rawGate = comparatorOne;
         default: rawGate = comparatorTwo;
      endcase
   end
   assign polGate = gateCfg_reg[GCT_POL] ? rawGate : ~rawGate;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gateLast_reg <= 1'b0;
      end else begin
         gateLast_reg <= polGate;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         toggle_reg <= 1'b0;
      end else if (!gateCfg_reg[GCT_TOGGLE]) begin
         toggle_reg <= 1'b0;
      end else if (polGate && !gateLast_reg) begin
         toggle_reg <= ~toggle_reg;
      end
   end
   // single pulse: wait for the gate to open, count while open, then stop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         spState_reg <= GTC_SP_IDLE;
      end else begin
         case (spState_reg)
            GTC_SP_IDLE: begin
               if (arm_reg && gateCfg_reg[GCT_SPM]) begin
                  spState_reg <= GTC_SP_WAIT;
               end
            end
            GTC_SP_WAIT: begin
               if (!gateCfg_reg[GCT_SPM] || !arm_reg) begin
                  spState_reg <= GTC_SP_IDLE;
               end else if (effGate) begin
                  spState_reg <= GTC_SP_PULSE;
               end
            end
            GTC_SP_PULSE: begin
               if (!gateCfg_reg[GCT_SPM] || !effGate) begin
                  spState_reg <= GTC_SP_IDLE;
               end
            end
            default: spState_reg <= GTC_SP_IDLE;
         endcase
      end
   end
   assign effGate = gateCfg_reg[GCT_TOGGLE] ? toggle_reg : polGate;
   assign gateOpen = gateCfg_reg[GCT_SPM]
                     ? (spState_reg == GTC_SP_PULSE) : effGate;
   assign countStep = control_reg[CTL_TIMER_ON] && prescaleHit
                      && (!gateCfgEnable_reg || gateOpen);
   // control and gate config registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         control_reg <= CONTROL_RESET;
      end else if (wrEn && paddr == ADDR_CONTROL) begin
         control_reg <= pwdata[7:0] & 8'hfd;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gateCfgEnable_reg <= GATE_CONTROL_RESET[GCT_ENABLE];
         gateCfg_reg <= GATE_CONTROL_RESET[GCT_SPM +: 3];
         gateCfgSrc_reg <= GATE_CONTROL_RESET[GCT_SRC_LO +: 2];
      end else if (wrEn && paddr == ADDR_GATE_CONTROL) begin
         gateCfgEnable_reg <= pwdata[GCT_ENABLE];
         gateCfg_reg <= pwdata[GCT_SPM +: 3];
         gateCfgSrc_reg <= pwdata[GCT_SRC_LO +: 2];
      end
   end
   // arm bit: software sets, device clears at end of pulse
   // the write sees the new mode bit, so one write can enable and arm
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arm_reg <= GATE_CONTROL_RESET[GCT_ARM];
      end else if (spState_reg == GTC_SP_PULSE && !effGate) begin
         arm_reg <= 1'b0;
      end else if (wrEn && paddr == ADDR_GATE_CONTROL) begin
         arm_reg <= pwdata[GCT_ARM] & pwdata[GCT_SPM];
      end else if (!gateCfg_reg[GCT_SPM]) begin
         arm_reg <= 1'b0;
      end
   end
   // count: trigger beats software write beats increment
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_reg <= COUNT_RESET;
      end else if (specialEventTrigger) begin
         count_reg <= COUNT_RESET;
      end else if (wrEn && paddr == ADDR_COUNT_VALUE) begin
         count_reg <= pwdata[15:0];
      end else if (countStep) begin
         count_reg <= count_reg + 16'h0001;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= countStep && count_reg == 16'hffff
                    && !specialEventTrigger
                    && !(wrEn && paddr == ADDR_COUNT_VALUE);
      end
   end
   assign overflowIrq = irq_reg;
   // read mux, registered into prdata on setup so it is valid in access
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (paddr == ADDR_CONTROL) begin
         rdata_next[7:0] = control_reg;
      end else if (paddr == ADDR_GATE_CONTROL) begin
         rdata_next[7:0] = {gateCfgEnable_reg, gateCfg_reg, arm_reg,
                            effGate, gateCfgSrc_reg};
      end else if (paddr == ADDR_COUNT_VALUE) begin
         rdata_next[15:0] = count_reg;
      end else if (paddr == ADDR_PERIOD_COUNT) begin
         rdata_next[7:0] = ptCount;
      end else if (paddr == ADDR_PERIOD_VALUE) begin
         rdata_next[7:0] = ptPeriod;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel) begin
         prdata <= rdata_next;
      end
   end
   AST_WRAP_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
      countStep && count_reg == 16'hffff && !specialEventTrigger
      && !(wrEn && paddr == ADDR_COUNT_VALUE)
      |=> overflowIrq && count_reg == 16'h0000)
      else $error("overflow did not raise irq");
   AST_TRIGGER_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      specialEventTrigger |=> count_reg == 16'h0000)
      else $error("trigger did not clear count");
   AST_FROZEN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
      !control_reg[CTL_TIMER_ON] && !specialEventTrigger
      && !(wrEn && paddr == ADDR_COUNT_VALUE)
      |=> $stable(count_reg))
      else $error("count moved while off");
   AST_GATE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      gateCfgEnable_reg && !gateCfg_reg[GCT_SPM] && !effGate
      && !specialEventTrigger && !(wrEn && paddr == ADDR_COUNT_VALUE)
      |=> $stable(count_reg))
      else $error("count moved with gate closed");
   AST_TOGGLE_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
      !gateCfg_reg[GCT_TOGGLE] |=> !toggle_reg)
      else $error("toggle flop not cleared");
   AST_ARM_DROP: assert property (@(posedge clk_sys) disable iff (rst)
      !gateCfg_reg[GCT_SPM] |-> !arm_reg)
      else $error("arm bit kept without single pulse");
   AST_POLARITY: assert property (@(posedge clk_sys) disable iff (rst)
      !gateCfg_reg[GCT_TOGGLE] && gateCfgSrc_reg == 2'b00
      |-> effGate == (gateCfg_reg[GCT_POL] ~^ gateInputPin))
      else $error("gate polarity wrong");
   AST_PULSE_DONE: assert property (@(posedge clk_sys) disable iff (rst)
      spState_reg == GTC_SP_PULSE && !effGate && gateCfg_reg[GCT_SPM]
      |=> !arm_reg && spState_reg == GTC_SP_IDLE)
      else $error("pulse end did not clear arm");
   AST_COUNT_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
      wrEn && paddr == ADDR_COUNT_VALUE && !specialEventTrigger
      |=> count_reg == $past(pwdata[15:0]))
      else $error("count write lost");
endmodule
`default_nettype wire
